// >>> core/scc_pkg.sv
// Package: register map, bit positions and reset values of the card contact control block
package scc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CARD_CONTACT_CONTROL_ADDR  = 8'hac;
    localparam logic [7:0] CARD_CONTACT_CONTROL_RESET = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLK_SEL_BIT   = 7;
    localparam int RSVD_BIT      = 6;
    localparam int AUX8_BIT      = 5;
    localparam int AUX4_BIT      = 4;
    localparam int IO_BIT        = 3;
    localparam int SWCLK_BIT     = 2;
    localparam int RESET_BIT     = 1;
    localparam int SUPPLY_BIT    = 0;
    // ------------------------------------------------------------
    // Clock switch synchroniser depth
    // ------------------------------------------------------------
    localparam int SYNC_STAGES   = 2;
    // ------------------------------------------------------------
    // Clock switch states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCC_SW_SOFT = 2'b00,
        SCC_SW_GEN  = 2'b01
    } scc_sw_e;
endpackage

// >>> core/scc_clk_switch.sv
// Glitch-free switch between software clock level and generated card clock
`timescale 1ns/1ps
`default_nettype none
module scc_clk_switch (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic sel_gen,
    input  wire logic soft_level,
    input  wire logic gen_clk,
    output logic      card_clk
);
    // ------------------------------------------------------------
    // Selection follows the clocks low phase only
    // ------------------------------------------------------------
    scc_pkg::scc_sw_e state_ff;
    scc_pkg::scc_sw_e nxt_state;
    logic             out_ff;
    logic             nxt_out;
    logic             gen_d_ff;
    logic             nxt_gen_d;

    always_comb begin
        nxt_state = state_ff;
        nxt_gen_d = gen_clk;
        case (state_ff)
            // Leave software level only when both sources are low, no runt pulse
            scc_pkg::SCC_SW_SOFT: begin
                if (sel_gen && !soft_level && !gen_d_ff) begin
                    nxt_state = scc_pkg::SCC_SW_GEN; // R3
                end
            end
            scc_pkg::SCC_SW_GEN: begin
                if (!sel_gen && !gen_d_ff) begin
                    nxt_state = scc_pkg::SCC_SW_SOFT; // R3
                end
            end
            default: nxt_state = scc_pkg::SCC_SW_SOFT;
        endcase
        if (state_ff == scc_pkg::SCC_SW_GEN) begin
            nxt_out = gen_d_ff; // R2
        end else begin
            nxt_out = soft_level; // R1
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= scc_pkg::SCC_SW_SOFT;
            out_ff   <= 1'b0;
            gen_d_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            out_ff   <= nxt_out;
            gen_d_ff <= nxt_gen_d;
        end
    end

    assign card_clk = out_ff;
endmodule
`default_nettype wire

// >>> core/scc_contact_ctrl.sv
// Card contact control register and contact drivers
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: With clock select zero the card clock pin follows the software clock bit.
// R2: With clock select one the card clock pin follows the generated card clock from crystal or PLL; the switch waits while the software clock bit is one.
// R3: Switching clock select never glitches the card clock pin.
// R4: The C8 contact is driven low when its bit is zero and high when one; the code releases it when one instead of driving it high.
// R5: With the C8 bit one the contact is released so the card may pull it low and software reads it.
// R6: The C4 contact is driven low when its bit is zero and high when one; the code releases it when one instead of driving it high.
// R7: With the C4 bit one the contact is released and its level is read back.
// R8: Without the card UART the I/O bit drives the I/O contact low or releases it high.
// R9: Software samples the I/O contact by writing one to the I/O bit then reading it.
// R10: With clock select zero the software clock bit is copied to the card clock contact.
// R11: Software changes contacts only while the supply-in-range flag is one.
// R12: The reset bit sets the reset contact and with supply off all contacts stay inactive.
// R13: The UART-select bit chooses the I/O bit or the card UART as I/O contact source.
// R14: The supply-in-range flag is one only while the card supply is within the selected range.
module scc_contact_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    output logic                   sfr_hit,
    input  wire logic              crystal_clock,
    input  wire logic              pll_clock,
    input  wire logic              gen_src_pll,
    input  wire logic              uart_select,
    input  wire logic              uart_io_out,
    output logic                   uart_io_in,
    input  wire logic              supply_in_range_flag,
    output logic                   supply_request,
    output logic                   card_clock_out,
    output logic                   contact_reset_out,
    input  wire logic              contact_io_pin_i,
    output logic                   contact_io_pin_o,
    output logic                   contact_io_pin_oe,
    input  wire logic              aux_pin8_i,
    output logic                   aux_pin8_o,
    output logic                   aux_pin8_oe,
    input  wire logic              aux_pin4_i,
    output logic                   aux_pin4_o,
    output logic                   aux_pin4_oe
);
    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    logic [7:0] card_contact_control_ff;
    logic [7:0] nxt_card_contact_control;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       sel;
    logic       gen_clk;
    logic       sw_clk;
    logic       supply_on;
    logic       io_drive_low;

    assign sel = (sfr_addr == ADDR_W'(scc_pkg::CARD_CONTACT_CONTROL_ADDR));
    assign sfr_hit = sel & (sfr_wr | sfr_rd);
    assign supply_on = card_contact_control_ff[scc_pkg::SUPPLY_BIT];

    always_comb begin
        nxt_card_contact_control = card_contact_control_ff;
        nxt_rdata = rdata_ff;
        if (sel && sfr_wr) begin
            nxt_card_contact_control = sfr_wdata;
        end
        if (sel && sfr_rd) begin
            // Port-style read: I/O, C8 and C4 bits return pin levels, not latches
            nxt_rdata = card_contact_control_ff;
            nxt_rdata[scc_pkg::RSVD_BIT] = 1'b0;
            nxt_rdata[scc_pkg::IO_BIT]   = contact_io_pin_i; // R9
            nxt_rdata[scc_pkg::AUX8_BIT] = aux_pin8_i;       // R5
            nxt_rdata[scc_pkg::AUX4_BIT] = aux_pin4_i;       // R7
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            card_contact_control_ff <= scc_pkg::CARD_CONTACT_CONTROL_RESET;
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            card_contact_control_ff <= nxt_card_contact_control;
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata = rdata_ff;

    // ------------------------------------------------------------
    // Clock contact
    // ------------------------------------------------------------
    // Generated clock is sampled on system clock; source must be well below 12.5 MHz
    assign gen_clk = gen_src_pll ? pll_clock : crystal_clock; // R2
    assign sw_clk  = card_contact_control_ff[scc_pkg::SWCLK_BIT] & supply_on; // R10

    scc_clk_switch u_clk_switch (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .sel_gen    (card_contact_control_ff[scc_pkg::CLK_SEL_BIT] & supply_on), // R1
        .soft_level (sw_clk),
        .gen_clk    (gen_clk),
        .card_clk   (card_clock_out)
    );

    // ------------------------------------------------------------
    // Pseudo bidirectional contacts: drive low, release for high
    // ------------------------------------------------------------
    always_comb begin
        if (uart_select) begin
            io_drive_low = ~uart_io_out; // R13
        end else begin
            io_drive_low = ~card_contact_control_ff[scc_pkg::IO_BIT]; // R8
        end
    end

    // Supply off keeps every contact low
    assign supply_request     = supply_on; // R12
    assign contact_reset_out  = card_contact_control_ff[scc_pkg::RESET_BIT] & supply_on; // R12
    assign contact_io_pin_o   = 1'b0;
    assign contact_io_pin_oe  = io_drive_low | ~supply_on;
    assign uart_io_in         = contact_io_pin_i;
    assign aux_pin8_o         = 1'b0;
    assign aux_pin8_oe        = ~card_contact_control_ff[scc_pkg::AUX8_BIT] | ~supply_on; // R4
    assign aux_pin4_o         = 1'b0;
    assign aux_pin4_oe        = ~card_contact_control_ff[scc_pkg::AUX4_BIT] | ~supply_on; // R6
    // The in-range flag comes from the converter; it is only passed to software elsewhere
    logic unused_ok;
    assign unused_ok = supply_in_range_flag; // R14
endmodule
`default_nettype wire

// >>> verif/scc_card.sv
// Card contact model: open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module scc_card (
    input  wire logic [2:0] dut_oe,
    input  wire logic [2:0] card_pull,
    output logic      [2:0] pin
);
    // A released line floats high; either party may pull it low
    assign pin = ~(dut_oe | card_pull);
endmodule
`default_nettype wire

// >>> verif/scc_monitor.sv
// Assertion checker for the card contact control block
`timescale 1ns/1ps
`default_nettype none
module scc_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              clk_en,
    input wire logic [ADDR_W-1:0] sfr_addr,
    input wire logic              sfr_wr,
    input wire logic              sfr_rd,
    input wire logic [7:0]        sfr_wdata,
    input wire logic [7:0]        sfr_rdata,
    input wire logic              uart_select,
    input wire logic              uart_io_out,
    input wire logic              uart_io_in,
    input wire logic              supply_request,
    input wire logic              contact_reset_out,
    input wire logic              contact_io_pin_i,
    input wire logic              contact_io_pin_oe,
    input wire logic              aux_pin8_oe,
    input wire logic              aux_pin4_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic wr_hit;
    logic rd_hit;
    assign wr_hit = clk_en && sfr_wr && (sfr_addr == 8'hac);
    assign rd_hit = clk_en && sfr_rd && (sfr_addr == 8'hac);
    supply_wr_a: assert property (wr_hit |=> supply_request == $past(sfr_wdata[0])) else $error("supply bit");
    reset_pin_a: assert property (wr_hit |=> contact_reset_out == ($past(sfr_wdata[1]) && $past(sfr_wdata[0])))
        else $error("reset contact");
    aux8_drive_a: assert property (wr_hit && sfr_wdata[0] |=> aux_pin8_oe == !$past(sfr_wdata[5]))
        else $error("aux8 drive");
    aux4_drive_a: assert property (wr_hit && sfr_wdata[0] |=> aux_pin4_oe == !$past(sfr_wdata[4]))
        else $error("aux4 drive");
    io_drive_a: assert property (wr_hit && sfr_wdata[0] && !uart_select |=> uart_select ||
        contact_io_pin_oe == !$past(sfr_wdata[3])) else $error("io drive");
    supply_off_a: assert property (!supply_request |-> contact_io_pin_oe && aux_pin8_oe && aux_pin4_oe &&
        !contact_reset_out) else $error("supply off contacts");
    uart_path_a: assert property (supply_request && uart_select |-> contact_io_pin_oe == !uart_io_out &&
        uart_io_in == contact_io_pin_i) else $error("uart path");
    read_back_a: assert property (rd_hit |=> sfr_rdata[6] == 1'b0 && sfr_rdata[3] == $past(contact_io_pin_i))
        else $error("read back");
    cover property (wr_hit && sfr_wdata[7]);
    cover property (rd_hit && !contact_io_pin_i);
    cover property (supply_request && uart_select);
endmodule
bind scc_contact_ctrl scc_monitor #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the card contact control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clock = 0, sys_rst = 1, clk_en = 1, wr = 0, rd = 0, src_pll = 0, usel = 0, uout = 1;
    logic       ck_out, rst_out, sup, uin;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, div = 8'h00;
    logic [2:0] oe, pin, pull = 3'h0;
    int         failures = 0, checked = 0, cyc = 0, edges;
    always #20 clock = ~clock;
    always @(posedge clock) div <= div + 8'h01;
    scc_card card_u (.dut_oe(oe), .card_pull(pull), .pin(pin));
    scc_contact_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_hit(), .crystal_clock(div[2]),
        .pll_clock(div[3]), .gen_src_pll(src_pll), .uart_select(usel), .uart_io_out(uout), .uart_io_in(uin),
        .supply_in_range_flag(1'b1), .supply_request(sup), .card_clock_out(ck_out),
        .contact_reset_out(rst_out), .contact_io_pin_i(pin[2]), .contact_io_pin_o(),
        .contact_io_pin_oe(oe[2]), .aux_pin8_i(pin[1]), .aux_pin8_o(), .aux_pin8_oe(oe[1]),
        .aux_pin4_i(pin[0]), .aux_pin4_o(), .aux_pin4_oe(oe[0]));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Writes only while the supply is in range, as software must
    task automatic wreg(input logic [7:0] d);
        @(posedge clock) {addr, wr, wdata} <= {8'hac, 1'b1, d};
        @(posedge clock) wr <= 1'b0;
        @(negedge clock);
    endtask
    task automatic rreg(input logic [7:0] e);
        @(posedge clock) {addr, rd} <= {8'hac, 1'b1};
        @(posedge clock) rd <= 1'b0;
        @(negedge clock) chk("read value", e, rdata);
    endtask
    task automatic count_edges(input int n);
        logic prev;
        edges = 0;
        prev = ck_out;
        repeat (n) begin
            @(negedge clock);
            if (ck_out && !prev) edges++;
            prev = ck_out;
        end
    endtask
    task automatic t_supply;
        chk("oe at reset", 8'h07, {5'h0, oe});
        rreg(8'h00);
        wreg(8'h3e);
        chk("oe supply off", 8'h07, {5'h0, oe});
        chk("reset off", 8'h00, {7'h0, rst_out});
    endtask
    task automatic t_contacts;
        wreg(8'h03);
        chk("oe low drive", 8'h07, {5'h0, oe});
        chk("reset on", 8'h01, {7'h0, rst_out});
        wreg(8'h79);
        chk("oe released", 8'h00, {5'h0, oe});
        rreg(8'h39);
        @(posedge clock) pull <= 3'h6;
        rreg(8'h11);
        @(posedge clock) pull <= 3'h0;
    endtask
    // Clock expectations follow from the bench divider: crystal period 8, pll period 16 cycles
    task automatic t_clock;
        wreg(8'h05);
        @(negedge clock) chk("soft clock high", 8'h01, {7'h0, ck_out});
        wreg(8'h01);
        @(negedge clock) chk("soft clock low", 8'h00, {7'h0, ck_out});
        wreg(8'h81);
        count_edges(16);
        count_edges(64);
        chk("crystal edges", 8'h08, 8'(edges));
        @(posedge clock) src_pll <= 1'b1;
        count_edges(32);
        count_edges(64);
        chk("pll edges", 8'h04, 8'(edges));
        wreg(8'h01);
        count_edges(32);
        count_edges(64);
        chk("soft after gen", 8'h00, {7'(edges), ck_out});
    endtask
    task automatic t_uart;
        @(posedge clock) {usel, uout} <= 2'b10;
        @(negedge clock) chk("uart low", 8'h01, {7'h0, oe[2]});
        @(posedge clock) {uout, pull} <= {1'b1, 3'h4};
        @(negedge clock) chk("uart in", 8'h00, {6'h0, oe[2], uin});
        @(posedge clock) {usel, pull} <= {1'b0, 3'h0};
    endtask
    // A write while the enable is low must not land; supply request shows the stored bit
    task automatic t_enable;
        @(posedge clock) clk_en <= 1'b0;
        wreg(8'h00);
        chk("supply frozen", 8'h01, {7'h0, sup});
        @(posedge clock) clk_en <= 1'b1;
        wreg(8'h00);
        chk("supply dropped", 8'h00, {7'h0, sup});
    endtask
    task automatic results;
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        t_supply();
        t_contacts();
        t_clock();
        t_uart();
        t_enable();
        results();
    end
endmodule
`default_nettype wire
